/* File: design/gpio_pkg.sv */
// Purpose: shared constants and types for the three-port general purpose I/O block
// Assumes: registers are 8 bits wide and sit in the low byte of 32-bit Wishbone words
// Notes:   register indices are word indices, so the byte address is four times the index
package gpio_pkg;

   localparam int DW = 8;

   // register word indices, byte address = index * 4
   localparam logic [7:0] IDX_PORT_B_DATA = 8'h06;
   localparam logic [7:0] IDX_PORT_C_DATA = 8'h07;
   localparam logic [7:0] IDX_PORT_D_DATA = 8'h08;
   localparam logic [7:0] IDX_IRQ_STATUS  = 8'h0B;
   localparam logic [7:0] IDX_OPTIONS     = 8'h81;
   localparam logic [7:0] IDX_PORT_B_DIR  = 8'h86;
   localparam logic [7:0] IDX_PORT_C_DIR  = 8'h87;
   localparam logic [7:0] IDX_PORT_D_DIR  = 8'h88;
   localparam logic [7:0] IDX_CTRL_CFG    = 8'h89;
   localparam logic [7:0] IDX_IRQ_MASK    = 8'h8B;

   // reset values
   localparam logic [7:0] RST_OPTIONS  = 8'hFF;
   localparam logic [7:0] RST_DIR      = 8'hFF;
   localparam logic [7:0] RST_CTRL_CFG = 8'h07;
   localparam logic [7:0] RST_LATCH    = 8'h00;
   localparam logic [7:0] RST_IRQ_MASK = 8'h00;
   localparam logic [7:0] RST_IRQ_STAT = 8'h00;

   // field positions and masks
   localparam int         OPT_PULLUP_DIS_BIT = 7;
   localparam int         OPT_EDGE_BIT       = 6;
   localparam int         CFG_PSP_BIT        = 4;
   localparam logic [7:0] CFG_WR_MASK        = 8'h17;
   localparam int         IRQ_CHANGE_BIT     = 0;
   localparam int         IRQ_EXT_BIT        = 1;
   localparam logic [7:0] IRQ_IMPL_MASK      = 8'h03;
   localparam int         EXT_IRQ_PIN        = 0;
   localparam int         PROG_CLK_PIN       = 6;
   localparam int         PROG_DATA_PIN      = 7;
   localparam int         CHANGE_LO          = 4;
   localparam int         CHANGE_HI          = 7;

   typedef enum logic [0:0] {
      BUS_IDLE = 1'b0,
      BUS_ACK  = 1'b1
   } bus_state_e;

   typedef struct packed {
      logic [DW-1:0] latch;
      logic [DW-1:0] dir;
   } bank_state_s;

endpackage

/* File: design/bank_if.sv */
// Purpose: carries the write strobes and held state between the top and one port bank
// Assumes: one bank per 8-bit port
// Notes:   the owner modport is the bank, the user modport is the register logic
`timescale 1ns/1ps
`default_nettype none
interface bank_if;
   logic                   wr_latch;
   logic                   wr_dir;
   logic                   warm;
   logic [gpio_pkg::DW-1:0] wr_value;
   logic [gpio_pkg::DW-1:0] latch;
   logic [gpio_pkg::DW-1:0] dir;

   modport owner (input wr_latch, input wr_dir, input warm, input wr_value, output latch, output dir);
   modport user  (output wr_latch, output wr_dir, output warm, output wr_value, input latch, input dir);
endinterface
`default_nettype wire

/* File: design/gpio_bank.sv */
// Purpose: output latch and direction register of one 8-bit port
// Assumes: reset input is already synchronised to the clock
// Notes:   warm reset restores the direction but leaves the output latch alone
`timescale 1ns/1ps
`default_nettype none
module gpio_bank (
   input  wire logic clk_sys_i,
   input  wire logic rst_n_i,
   bank_if.owner     bank
);

   gpio_pkg::bank_state_s state_reg;
   gpio_pkg::bank_state_s state_next;

   always_comb begin
      state_next = state_reg;
      if (bank.wr_latch) begin
         state_next.latch = bank.wr_value;
      end
      if (bank.wr_dir) begin
         state_next.dir = bank.wr_value;
      end
      // other resets keep the latch, only the direction returns to all inputs
      if (bank.warm) begin
         state_next.dir = gpio_pkg::RST_DIR;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         // the latch is undefined after power-on; zero is one legal value
         state_reg.latch <= gpio_pkg::RST_LATCH;
         state_reg.dir   <= gpio_pkg::RST_DIR;
      end else begin
         state_reg <= state_next;
      end
   end

   assign bank.latch = state_reg.latch;
   assign bank.dir   = state_reg.dir;

endmodule
`default_nettype wire

/* File: design/gpio_ports.sv */
// Purpose: three 8-bit general purpose ports with pull-ups, change and external interrupts
// Assumes: all pin inputs are synchronous to clk_sys_i; Wishbone classic slave, 32-bit data
// Notes:   registers occupy the low byte of each word; upper bits read as zero
// Behaviour
// - second port bit 0 doubles as external interrupt
// - every second-port pin has switchable weak pull-up
// - second-port pins 4-7 detect interrupt on change
// - pin 6 is programming clock in programming mode
// - pin 7 is programming data in programming mode
// - power-on leaves latches undefined, other resets keep them
// - third port: 8 readable, drivable bidirectional pins
// - third-port direction set per pin
// - fourth port: 8 pins, per-pin direction
// - slave-select bit 4 makes fourth port data bus
// - slave mode: fourth-port pin n is bit n
// - direction one floats pin, zero drives latch
// - reads return pins; writes read-modify-write the latch
// - pull-up disable bit 7 clear enables inputs' pull-ups
// - input pins 4-7 mismatch with last read sets flag
`timescale 1ns/1ps
`default_nettype none
module gpio_ports (
   input  wire logic        clk_sys_i,
   input  wire logic        reset_n_i,
   input  wire logic        warm_reset_i,
   input  wire logic        wb_cyc_i,
   input  wire logic        wb_stb_i,
   input  wire logic        wb_we_i,
   input  wire logic [9:0]  wb_adr_i,
   input  wire logic [3:0]  wb_sel_i,
   input  wire logic [31:0] wb_dat_i,
   output logic      [31:0] wb_dat_o,
   output logic             wb_ack_o,
   output logic             irq_o,
   input  wire logic [7:0]  port_b_in_i,
   output logic      [7:0]  port_b_out_o,
   output logic      [7:0]  port_b_oe_o,
   output logic      [7:0]  port_b_pullup_o,
   input  wire logic [7:0]  port_c_in_i,
   output logic      [7:0]  port_c_out_o,
   output logic      [7:0]  port_c_oe_o,
   input  wire logic [7:0]  port_d_in_i,
   output logic      [7:0]  port_d_out_o,
   output logic      [7:0]  port_d_oe_o,
   input  wire logic        prog_mode_i,
   output logic             prog_clock_o,
   output logic             prog_data_o,
   input  wire logic        prog_data_out_i,
   input  wire logic        prog_data_oe_i,
   input  wire logic        psp_drive_i,
   input  wire logic [7:0]  psp_data_i,
   output logic      [7:0]  psp_data_o
);

   typedef struct packed {
      gpio_pkg::bus_state_e bus;
      logic [7:0]           rdata;
      logic [7:0]           option;
      logic [7:0]           ctrl_cfg;
      logic [7:0]           irq_status;
      logic [7:0]           irq_mask;
      logic [3:0]           change_snap;
      logic                 ext_prev;
      logic [7:0]           psp_data;
   } state_s;

   state_s     state_reg;
   state_s     state_next;
   logic [1:0] rst_sync_reg;
   logic       rst_n;

   // asynchronous assert, synchronous release
   always_ff @(posedge clk_sys_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         rst_sync_reg <= 2'h0;
      end else begin
         rst_sync_reg <= {rst_sync_reg[0], 1'b1};
      end
   end
   assign rst_n = rst_sync_reg[1];

   bank_if bank_b ();
   bank_if bank_c ();
   bank_if bank_d ();

   gpio_bank u_bank_b (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n),
      .bank      (bank_b)
   );

   gpio_bank u_bank_c (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n),
      .bank      (bank_c)
   );

   gpio_bank u_bank_d (
      .clk_sys_i (clk_sys_i),
      .rst_n_i   (rst_n),
      .bank      (bank_d)
   );

   logic       req;
   logic       commit;
   logic       wr_commit;
   logic       lane0;
   logic [7:0] idx;
   logic [7:0] wbyte;
   logic [7:0] rd_val;
   logic       psp_mode;
   logic [3:0] mismatch;
   logic       ext_edge;
   logic [7:0] irq_set;
   logic [7:0] irq_clr;

   assign req       = wb_cyc_i & wb_stb_i;
   assign idx       = wb_adr_i[9:2];
   assign wbyte     = wb_dat_i[7:0];
   assign lane0     = wb_sel_i[0];
   // the access takes effect at the edge where the master sees ack
   assign commit    = req & (state_reg.bus == gpio_pkg::BUS_ACK);
   assign wr_commit = commit & wb_we_i;
   assign psp_mode  = state_reg.ctrl_cfg[gpio_pkg::CFG_PSP_BIT];

   // read decode: data registers return the pin levels, not the latches
   always_comb begin
      rd_val = 8'h00;
      unique case (idx)
         gpio_pkg::IDX_PORT_B_DATA: rd_val = port_b_in_i;
         gpio_pkg::IDX_PORT_C_DATA: rd_val = port_c_in_i;
         gpio_pkg::IDX_PORT_D_DATA: rd_val = port_d_in_i;
         gpio_pkg::IDX_OPTIONS:     rd_val = state_reg.option;
         gpio_pkg::IDX_PORT_B_DIR:  rd_val = bank_b.dir;
         gpio_pkg::IDX_PORT_C_DIR:  rd_val = bank_c.dir;
         gpio_pkg::IDX_PORT_D_DIR:  rd_val = bank_d.dir;
         gpio_pkg::IDX_CTRL_CFG:    rd_val = state_reg.ctrl_cfg;
         gpio_pkg::IDX_IRQ_STATUS:  rd_val = state_reg.irq_status;
         gpio_pkg::IDX_IRQ_MASK:    rd_val = state_reg.irq_mask;
         default:                   rd_val = 8'h00;
      endcase
   end

   // writes to a data register are read-modify-write: lanes not selected take the pin level
   always_comb begin
      bank_b.wr_value = lane0 ? wbyte : port_b_in_i;
      bank_b.wr_latch = wr_commit & (idx == gpio_pkg::IDX_PORT_B_DATA);
      bank_b.wr_dir   = wr_commit & lane0 & (idx == gpio_pkg::IDX_PORT_B_DIR);
      bank_b.warm     = warm_reset_i;
      bank_c.wr_value = lane0 ? wbyte : port_c_in_i;
      bank_c.wr_latch = wr_commit & (idx == gpio_pkg::IDX_PORT_C_DATA);
      bank_c.wr_dir   = wr_commit & lane0 & (idx == gpio_pkg::IDX_PORT_C_DIR);
      bank_c.warm     = warm_reset_i;
      bank_d.wr_value = lane0 ? wbyte : port_d_in_i;
      bank_d.wr_latch = wr_commit & (idx == gpio_pkg::IDX_PORT_D_DATA);
      bank_d.wr_dir   = wr_commit & lane0 & (idx == gpio_pkg::IDX_PORT_D_DIR);
      bank_d.warm     = warm_reset_i;
   end

   // change detection looks only at pins set as inputs
   assign mismatch = (port_b_in_i[gpio_pkg::CHANGE_HI:gpio_pkg::CHANGE_LO] ^ state_reg.change_snap)
                     & bank_b.dir[gpio_pkg::CHANGE_HI:gpio_pkg::CHANGE_LO];

   // edge select bit high means rising edge
   assign ext_edge = state_reg.option[gpio_pkg::OPT_EDGE_BIT]
                     ? (port_b_in_i[gpio_pkg::EXT_IRQ_PIN] & ~state_reg.ext_prev)
                     : (~port_b_in_i[gpio_pkg::EXT_IRQ_PIN] & state_reg.ext_prev);

   always_comb begin
      irq_set = 8'h00;
      irq_set[gpio_pkg::IRQ_CHANGE_BIT] = |mismatch;
      irq_set[gpio_pkg::IRQ_EXT_BIT]    = ext_edge;
      irq_clr = 8'h00;
      if (wr_commit && lane0 && idx == gpio_pkg::IDX_IRQ_STATUS) begin
         irq_clr = wbyte & gpio_pkg::IRQ_IMPL_MASK;
      end
   end

   always_comb begin
      state_next          = state_reg;
      state_next.ext_prev = port_b_in_i[gpio_pkg::EXT_IRQ_PIN];
      // an event in the same cycle as its clear keeps the flag set
      state_next.irq_status = (state_reg.irq_status & ~irq_clr) | irq_set;
      unique case (state_reg.bus)
         gpio_pkg::BUS_IDLE: begin
            if (req) begin
               state_next.bus   = gpio_pkg::BUS_ACK;
               state_next.rdata = rd_val;
            end
         end
         gpio_pkg::BUS_ACK: begin
            state_next.bus = gpio_pkg::BUS_IDLE;
         end
      endcase
      // any read or write of the second port re-arms the comparison
      if (commit && idx == gpio_pkg::IDX_PORT_B_DATA) begin
         state_next.change_snap = port_b_in_i[gpio_pkg::CHANGE_HI:gpio_pkg::CHANGE_LO];
      end
      if (wr_commit && lane0) begin
         unique case (idx)
            gpio_pkg::IDX_OPTIONS:  state_next.option = wbyte;
            gpio_pkg::IDX_CTRL_CFG: state_next.ctrl_cfg =
                                       (state_reg.ctrl_cfg & ~gpio_pkg::CFG_WR_MASK)
                                       | (wbyte & gpio_pkg::CFG_WR_MASK);
            gpio_pkg::IDX_IRQ_MASK: state_next.irq_mask = wbyte & gpio_pkg::IRQ_IMPL_MASK;
            default: begin
            end
         endcase
      end
      if (psp_mode) begin
         state_next.psp_data = port_d_in_i;
      end
      if (warm_reset_i) begin
         state_next.option   = gpio_pkg::RST_OPTIONS;
         state_next.ctrl_cfg = gpio_pkg::RST_CTRL_CFG;
      end
   end

   always_ff @(posedge clk_sys_i or negedge rst_n) begin
      if (!rst_n) begin
         state_reg.bus         <= gpio_pkg::BUS_IDLE;
         state_reg.rdata       <= 8'h00;
         state_reg.option      <= gpio_pkg::RST_OPTIONS;
         state_reg.ctrl_cfg    <= gpio_pkg::RST_CTRL_CFG;
         state_reg.irq_status  <= gpio_pkg::RST_IRQ_STAT;
         state_reg.irq_mask    <= gpio_pkg::RST_IRQ_MASK;
         state_reg.change_snap <= 4'h0;
         state_reg.ext_prev    <= 1'b0;
         state_reg.psp_data    <= 8'h00;
      end else begin
         state_reg <= state_next;
      end
   end

   assign wb_ack_o = state_reg.bus == gpio_pkg::BUS_ACK;
   assign wb_dat_o = {24'h000000, state_reg.rdata};
   assign irq_o    = |(state_reg.irq_status & state_reg.irq_mask);

   // second port pins; programming mode takes over pins 6 and 7
   always_comb begin
      port_b_out_o = bank_b.latch;
      port_b_oe_o  = ~bank_b.dir;
      if (prog_mode_i) begin
         port_b_oe_o[gpio_pkg::PROG_CLK_PIN]  = 1'b0;
         port_b_out_o[gpio_pkg::PROG_DATA_PIN] = prog_data_out_i;
         port_b_oe_o[gpio_pkg::PROG_DATA_PIN]  = prog_data_oe_i;
      end
      // a pull-up is never on against a pin that is driven
      port_b_pullup_o = {8{~state_reg.option[gpio_pkg::OPT_PULLUP_DIS_BIT]}} & ~port_b_oe_o;
   end

   assign prog_clock_o = prog_mode_i & port_b_in_i[gpio_pkg::PROG_CLK_PIN];
   assign prog_data_o  = prog_mode_i & port_b_in_i[gpio_pkg::PROG_DATA_PIN];

   // third port is plain bidirectional I/O
   assign port_c_out_o = bank_c.latch;
   assign port_c_oe_o  = ~bank_c.dir;

   // fourth port: bus data word in slave mode, ordinary I/O otherwise
   always_comb begin
      if (psp_mode) begin
         port_d_out_o = psp_data_i;
         port_d_oe_o  = {8{psp_drive_i}};
      end else begin
         port_d_out_o = bank_d.latch;
         port_d_oe_o  = ~bank_d.dir;
      end
   end

   assign psp_data_o = state_reg.psp_data;

endmodule
`default_nettype wire

/* File: testbench/gpio_pins_model.sv */
// Purpose: pin-side model of one 8-bit port: external drivers, weak pull-up, floating pins
// Assumes: the bench may drive a pin externally while the block drives it; the block's level wins
// Notes:   a floating pin toggles every cycle so no stale level can pass for a real one
`timescale 1ns/1ps
`default_nettype none
module gpio_pins_model (
   input  wire logic       clk_i,
   input  wire logic [7:0] out_i,
   input  wire logic [7:0] oe_i,
   input  wire logic [7:0] pullup_i,
   input  wire logic [7:0] ext_en_i,
   input  wire logic [7:0] ext_val_i,
   output logic      [7:0] pin_o
);
   logic [7:0] float_reg = 8'h5A;

   always_ff @(posedge clk_i) begin
      float_reg <= ~float_reg;
   end

   // block drive wins, then outside drivers, then the weak pull-up
   always_comb begin
      pin_o = (oe_i & out_i) | (~oe_i & ext_en_i & ext_val_i) | (~oe_i & ~ext_en_i & (pullup_i | float_reg));
   end
endmodule
`default_nettype wire

/* File: testbench/gpio_ports_sva.sv */
// Purpose: port-level checks on the three-port I/O block
// Assumes: Wishbone master keeps cyc and stb low for a cycle after each ack
// Notes:   register contents are not visible here, so checks tie outputs to pins and bus
`timescale 1ns/1ps
`default_nettype none
module gpio_ports_sva (
   input wire logic        clk_sys_i,
   input wire logic        reset_n_i,
   input wire logic        wb_cyc_i,
   input wire logic        wb_stb_i,
   input wire logic        wb_we_i,
   input wire logic [31:0] wb_dat_o,
   input wire logic        wb_ack_o,
   input wire logic        irq_o,
   input wire logic [7:0]  port_b_in_i,
   input wire logic [7:0]  port_b_out_o,
   input wire logic [7:0]  port_b_oe_o,
   input wire logic [7:0]  port_b_pullup_o,
   input wire logic        prog_mode_i,
   input wire logic        prog_clock_o,
   input wire logic        prog_data_o,
   input wire logic        prog_data_out_i,
   input wire logic        prog_data_oe_i,
   input wire logic [7:0]  port_d_in_i,
   input wire logic [7:0]  psp_data_o
);
   default clocking cb @(posedge clk_sys_i); endclocking
   default disable iff (!reset_n_i);

   a_ack_one_cycle: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
      else $error("ack did not follow the request");
   a_ack_single_pulse: assert property (wb_ack_o |=> !wb_ack_o)
      else $error("ack held longer than one cycle");
   a_read_data_hold: assert property (!$past(wb_cyc_i && wb_stb_i) |-> $stable(wb_dat_o) && wb_dat_o[31:8] == 24'h0)
      else $error("read data moved without an access");
   a_irq_clear_cause: assert property ($fell(irq_o) |-> $past(wb_ack_o && wb_we_i))
      else $error("interrupt dropped without a register write");
   a_pullup_output_off: assert property ((port_b_pullup_o & port_b_oe_o) == 8'h00)
      else $error("pull-up on a driven pin");
   a_prog_clock_path: assert property (prog_clock_o == (prog_mode_i && port_b_in_i[6]))
      else $error("programming clock wrong");
   a_prog_data_path: assert property (prog_data_o == (prog_mode_i && port_b_in_i[7]))
      else $error("programming data input wrong");
   a_prog_data_drive: assert property (prog_mode_i |-> port_b_oe_o[7] == prog_data_oe_i && !port_b_oe_o[6] && port_b_out_o[7] == prog_data_out_i)
      else $error("programming pins driven wrongly");
   a_psp_capture_pins: assert property ($changed(psp_data_o) |-> psp_data_o == $past(port_d_in_i))
      else $error("slave data not taken from the pins");
endmodule

bind gpio_ports gpio_ports_sva u_sva (.clk_sys_i, .reset_n_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_dat_o, .wb_ack_o,
   .irq_o, .port_b_in_i, .port_b_out_o, .port_b_oe_o, .port_b_pullup_o, .prog_mode_i, .prog_clock_o, .prog_data_o,
   .prog_data_out_i, .prog_data_oe_i, .port_d_in_i, .psp_data_o);
`default_nettype wire

/* File: testbench/tb_top.sv */
// Purpose: self-checking bench for the three-port I/O block
// Assumes: pins are modelled by gpio_pins_model, registers reached over Wishbone
// Notes:   reads queue their expected value; a monitor compares at ack
`timescale 1ns/1ps
`default_nettype none
module tb_top;
   logic        clk_sys_i = 1'b0, reset_n_i = 1'b0, warm_reset_i = 1'b0, wb_ack_o, irq_o;
   logic        wb_cyc_i = 1'b0, wb_stb_i = 1'b0, wb_we_i = 1'b0, prog_clock_o, prog_data_o;
   logic        prog_mode_i = 1'b0, prog_data_out_i = 1'b0, prog_data_oe_i = 1'b0, psp_drive_i = 1'b0;
   logic [9:0]  wb_adr_i = 10'h000;
   logic [3:0]  wb_sel_i = 4'h0;
   logic [31:0] wb_dat_i = 32'h0000_0000, wb_dat_o;
   logic [7:0]  psp_data_i = 8'h00, psp_data_o, port_b_out_o, port_b_oe_o, port_b_pullup_o;
   logic [7:0]  port_c_out_o, port_c_oe_o, port_d_out_o, port_d_oe_o;
   logic [7:0]  be = 8'hFF, bv = 8'h00, ce = 8'hFF, cv = 8'h00, de = 8'hFF, dv = 8'h00;
   wire  [7:0]  port_b_in_i, port_c_in_i, port_d_in_i;
   logic [31:0] expq[$];
   int          fail_count = 0, checked = 0;

   gpio_ports DUT (.clk_sys_i, .reset_n_i, .warm_reset_i, .wb_cyc_i, .wb_stb_i, .wb_we_i, .wb_adr_i, .wb_sel_i,
      .wb_dat_i, .wb_dat_o, .wb_ack_o, .irq_o, .port_b_in_i, .port_b_out_o, .port_b_oe_o, .port_b_pullup_o,
      .port_c_in_i, .port_c_out_o, .port_c_oe_o, .port_d_in_i, .port_d_out_o, .port_d_oe_o, .prog_mode_i,
      .prog_clock_o, .prog_data_o, .prog_data_out_i, .prog_data_oe_i, .psp_drive_i, .psp_data_i, .psp_data_o);
   gpio_pins_model pins_b (.clk_i(clk_sys_i), .out_i(port_b_out_o), .oe_i(port_b_oe_o), .pullup_i(port_b_pullup_o),
      .ext_en_i(be), .ext_val_i(bv), .pin_o(port_b_in_i));
   gpio_pins_model pins_c (.clk_i(clk_sys_i), .out_i(port_c_out_o), .oe_i(port_c_oe_o), .pullup_i(8'h00),
      .ext_en_i(ce), .ext_val_i(cv), .pin_o(port_c_in_i));
   gpio_pins_model pins_d (.clk_i(clk_sys_i), .out_i(port_d_out_o), .oe_i(port_d_oe_o), .pullup_i(8'h00),
      .ext_en_i(de), .ext_val_i(dv), .pin_o(port_d_in_i));

   initial begin
      forever #12.5 clk_sys_i = ~clk_sys_i;
   end

   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      checked++;
      if (seen !== exp) begin
         fail_count++;
         $display("[FAIL] %0t ns: seen %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic print_verdict();
      if (fail_count == 0 && checked > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask

   // ends at the falling edge so callers sample settled outputs
   task automatic wb(input logic we, input logic [7:0] idx, input logic [7:0] d, input logic [3:0] sel = 4'hF);
      int n;
      n = 0;
      @(posedge clk_sys_i);
      {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'b11, we, idx, 2'b00, sel, 24'h0, d};
      // ack is sampled at the rising edge; the write lands and read data is taken there
      do @(posedge clk_sys_i); while (wb_ack_o !== 1'b1 && ++n < 40);
      if (n >= 40) begin
         fail_count++;
         print_verdict();
      end
      {wb_cyc_i, wb_stb_i} <= 2'b00;
      @(negedge clk_sys_i);
   endtask

   task automatic rd(input logic [7:0] idx, input logic [7:0] exp);
      expq.push_back({24'h0, exp});
      wb(1'b0, idx, 8'h00);
   endtask

   always @(posedge clk_sys_i) begin
      if (wb_ack_o === 1'b1 && wb_we_i === 1'b0 && expq.size() > 0)
         chk(wb_dat_o, expq.pop_front());
   end

   initial begin
      #(25 * 6000);
      fail_count++;
      print_verdict();
   end

   initial begin
      logic [7:0] ri[8], rv[8], d, v, e;
      ri = '{8'h81, 8'h86, 8'h87, 8'h88, 8'h89, 8'h8B, 8'h0B, 8'h40};
      rv = '{8'hFF, 8'hFF, 8'hFF, 8'hFF, 8'h07, 8'h00, 8'h00, 8'h00};
      void'($urandom(91));
      repeat (5) @(posedge clk_sys_i);
      reset_n_i <= 1'b1;
      repeat (3) @(negedge clk_sys_i);
      chk({port_b_oe_o, port_c_oe_o, port_d_oe_o, port_b_pullup_o}, 32'h0);
      for (int i = 0; i < 8; i++)
         rd(ri[i], rv[i]);
      for (int k = 0; k < 4; k++) begin
         {d, v, e} = 24'($urandom);
         @(posedge clk_sys_i);
         {ce, cv, de, dv} <= {d, e, ~d, e};
         wb(1'b1, 8'h87, d);
         wb(1'b1, 8'h07, v);
         wb(1'b1, 8'h88, ~d);
         wb(1'b1, 8'h08, v);
         chk({port_c_oe_o, port_d_oe_o, port_c_out_o, port_d_out_o}, {~d, d, v, v});
         rd(8'h07, (v & ~d) | (e & d));
         rd(8'h08, (v & d) | (e & ~d));
         wb(1'b1, 8'h07, ~v, 4'h0);
         chk(port_c_out_o, (v & ~d) | (e & d));
      end
      wb(1'b1, 8'h89, 8'h17);
      @(posedge clk_sys_i);
      {psp_drive_i, psp_data_i} <= {1'b1, v ^ e};
      repeat (2) @(negedge clk_sys_i);
      chk({port_d_oe_o, port_d_out_o, psp_data_o}, {8'hFF, v ^ e, v ^ e});
      @(posedge clk_sys_i);
      psp_drive_i <= 1'b0;
      wb(1'b1, 8'h89, 8'h07);
      chk(port_d_oe_o, d);
      {d, v, e} = 24'($urandom);
      wb(1'b1, 8'h06, 8'h00);
      wb(1'b1, 8'h86, d);
      wb(1'b1, 8'h81, 8'h7F);
      chk(port_b_pullup_o, d);
      @(posedge clk_sys_i);
      be <= 8'h00;
      rd(8'h06, d);
      wb(1'b1, 8'h81, 8'hFF);
      chk(port_b_pullup_o, 8'h00);
      @(posedge clk_sys_i);
      be <= 8'hFF;
      wb(1'b1, 8'h86, 8'hFF);
      rd(8'h06, 8'h00);
      wb(1'b1, 8'h0B, 8'h03);
      wb(1'b1, 8'h8B, 8'h01);
      @(posedge clk_sys_i);
      bv <= 8'h04;
      repeat (3) @(negedge clk_sys_i);
      chk(irq_o, 1'b0);
      @(posedge clk_sys_i);
      bv <= 8'h24;
      repeat (3) @(negedge clk_sys_i);
      chk(irq_o, 1'b1);
      rd(8'h0B, 8'h01);
      wb(1'b1, 8'h0B, 8'h01);
      chk(irq_o, 1'b1);
      rd(8'h06, 8'h24);
      wb(1'b1, 8'h0B, 8'h01);
      chk(irq_o, 1'b0);
      wb(1'b1, 8'h86, 8'hEF);
      wb(1'b1, 8'h06, 8'h10);
      wb(1'b1, 8'h0B, 8'h01);
      repeat (2) @(negedge clk_sys_i);
      chk(irq_o, 1'b0);
      wb(1'b1, 8'h8B, 8'h02);
      @(posedge clk_sys_i);
      bv <= 8'h25;
      repeat (3) @(negedge clk_sys_i);
      chk(irq_o, 1'b1);
      rd(8'h0B, 8'h02);
      wb(1'b1, 8'h0B, 8'h02);
      chk(irq_o, 1'b0);
      // edge select low: the external interrupt follows the falling edge
      wb(1'b1, 8'h81, 8'hBF);
      @(posedge clk_sys_i);
      bv <= 8'h24;
      repeat (3) @(negedge clk_sys_i);
      chk(irq_o, 1'b1);
      wb(1'b1, 8'h0B, 8'h02);
      chk(irq_o, 1'b0);
      wb(1'b1, 8'h86, 8'h00);
      @(posedge clk_sys_i);
      bv <= 8'h40;
      {prog_mode_i, prog_data_oe_i, prog_data_out_i} <= 3'b111;
      @(negedge clk_sys_i);
      chk({port_b_oe_o[7:6], port_b_out_o[7], prog_clock_o, prog_data_o}, 5'b10111);
      @(posedge clk_sys_i);
      {prog_mode_i, prog_data_oe_i} <= 2'b00;
      wb(1'b1, 8'h87, 8'h00);
      wb(1'b1, 8'h07, 8'hA5);
      @(posedge clk_sys_i);
      warm_reset_i <= 1'b1;
      @(posedge clk_sys_i);
      warm_reset_i <= 1'b0;
      @(negedge clk_sys_i);
      chk({port_c_oe_o, port_c_out_o}, 16'h00A5);
      chk(expq.size(), 0);
      print_verdict();
   end
endmodule
`default_nettype wire
